// ==== tos_prio_defs.svh ====
`ifndef TOS_PRIO_DEFS_SVH
`define TOS_PRIO_DEFS_SVH

// register offsets of the table bytes held in this bank
`define TOS_PRIO_OFS_00_0C 8'h5F
`define TOS_PRIO_OFS_10_1C 8'h60
`define TOS_PRIO_OFS_20_2C 8'h62
`define TOS_PRIO_OFS_30_3C 8'h63
`define TOS_PRIO_OFS_40_4C 8'h64
`define TOS_PRIO_OFS_50_5C 8'h65
`define TOS_PRIO_OFS_60_6C 8'h66
`define TOS_PRIO_OFS_70_7C 8'h67
`define TOS_PRIO_OFS_80_8C 8'h68

// reset value of every table byte and the idle read value
`define TOS_PRIO_RST 8'h00
`define TOS_PRIO_RD_IDLE 8'h00
`define TOS_PRIO_NONE 2'h0

// code point field of the type-of-service byte
`define TOS_PRIO_IDX_MSB 7
`define TOS_PRIO_IDX_LSB 2

// table geometry
`define TOS_PRIO_FIELD_W 2
`define TOS_PRIO_BYTE_W 8
`define TOS_PRIO_SLOTS 9
`define TOS_PRIO_ENTRIES 64
`define TOS_PRIO_UPPER_FIELDS 28

`endif

// ==== tos_prio_pkg.sv ====
`default_nettype none
package tos_prio_pkg;
    // one priority field
    typedef logic [1:0] prio_t;
    // decoded code point index
    typedef logic [5:0] codeIdx_t;
    // one table byte
    typedef logic [7:0] regByte_t;
    // slot number inside this bank
    typedef logic [3:0] slot_t;
endpackage
`default_nettype wire

// ==== tos_prio_byte_reg.sv ====
`include "tos_prio_defs.svh"
`default_nettype none
module tos_prio_byte_reg #(
    parameter int W = `TOS_PRIO_BYTE_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // write side
    input wire logic wrEn,
    input wire logic [W-1:0] wrData,
    // stored value
    output logic [W-1:0] value
);
    // stored byte
    logic [W-1:0] value_q;

    // software write; cleared to priority zero on reset
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            value_q <= W'(`TOS_PRIO_RST);
        end
        else if (wrEn)
        begin
            value_q <= wrData;
        end
    end

    assign value = value_q;
endmodule
`default_nettype wire

// ==== tos_prio_select.sv ====
`include "tos_prio_defs.svh"
`default_nettype none
module tos_prio_select #(
    parameter int ENTRIES = `TOS_PRIO_ENTRIES,
    parameter int FW = `TOS_PRIO_FIELD_W
) (
    // flat table, entry i in bits [FW*i +: FW]
    input wire logic [ENTRIES*FW-1:0] tableBits,
    // code point index
    input wire logic [$clog2(ENTRIES)-1:0] codeIdx,
    // selected priority
    output logic [FW-1:0] prio
);
    // plain indexed part-select: one field per code point, no sharing
    always_comb
    begin
        prio = tableBits[FW*codeIdx +: FW];
    end
endmodule
`default_nettype wire

// ==== tos_priority_lookup_table.sv ====
`include "tos_prio_defs.svh"
`default_nettype none
module tos_priority_lookup_table #(
    parameter int SLOTS = `TOS_PRIO_SLOTS,
    parameter int UPPER_FIELDS = `TOS_PRIO_UPPER_FIELDS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // fields for code points 0x90 and up, from the adjacent bank
    input wire logic [UPPER_FIELDS*2-1:0] upperFields,
    // ingress parser side
    input wire logic tosValid,
    input wire logic [7:0] tosByte,
    input wire logic frameIsIpv4,
    input wire logic frameIsIpv6,
    input wire logic tosPrioEnable,
    // queueing side
    output logic prioValid,
    output logic [1:0] prioOut,
    output logic prioFromTos
);
    // width of the flat table
    localparam int FW = `TOS_PRIO_FIELD_W;
    localparam int ENTRIES = `TOS_PRIO_ENTRIES;
    localparam int LOW_BITS = SLOTS * `TOS_PRIO_BYTE_W;

    // decoded register port
    logic addrHit;
    tos_prio_pkg::slot_t addrSlot;
    // stored table bytes, one per slot
    tos_prio_pkg::regByte_t slotValue [SLOTS];
    // bytes of this bank flattened, slot 0 lowest
    logic [LOW_BITS-1:0] lowBits;
    // whole table as seen by the lookup
    logic [ENTRIES*FW-1:0] tableBits;
    // lookup path
    tos_prio_pkg::codeIdx_t codeIdx;
    tos_prio_pkg::prio_t prioSel;
    logic useTos;
    // registered outputs
    tos_prio_pkg::regByte_t rdData_q;
    logic prioValid_q;
    tos_prio_pkg::prio_t prio_q;
    logic fromTos_q;

    // does the address land on a byte of this bank
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            `TOS_PRIO_OFS_00_0C,
            `TOS_PRIO_OFS_10_1C,
            `TOS_PRIO_OFS_20_2C,
            `TOS_PRIO_OFS_30_3C,
            `TOS_PRIO_OFS_40_4C,
            `TOS_PRIO_OFS_50_5C,
            `TOS_PRIO_OFS_60_6C,
            `TOS_PRIO_OFS_70_7C,
            `TOS_PRIO_OFS_80_8C: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // slot of an address; slot s holds code point indices 4s..4s+3
    // note 0x61 is not part of the table, so offsets are not contiguous
    function automatic tos_prio_pkg::slot_t slotOf(input logic [7:0] addr);
        case (addr)
            // code points 0x00-0x0C
            `TOS_PRIO_OFS_00_0C: slotOf = 4'h0;
            // code points 0x10-0x1C
            `TOS_PRIO_OFS_10_1C: slotOf = 4'h1;
            // code points 0x20-0x2C
            `TOS_PRIO_OFS_20_2C: slotOf = 4'h2;
            // code points 0x30-0x3C
            `TOS_PRIO_OFS_30_3C: slotOf = 4'h3;
            // code points 0x40-0x4C
            `TOS_PRIO_OFS_40_4C: slotOf = 4'h4;
            // code points 0x50-0x5C
            `TOS_PRIO_OFS_50_5C: slotOf = 4'h5;
            // code points 0x60-0x6C
            `TOS_PRIO_OFS_60_6C: slotOf = 4'h6;
            // code points 0x70-0x7C
            `TOS_PRIO_OFS_70_7C: slotOf = 4'h7;
            // code points 0x80-0x8C
            `TOS_PRIO_OFS_80_8C: slotOf = 4'h8;
            // unmapped; guarded by isMapped
            default: slotOf = 4'h0;
        endcase
    endfunction

    // address decode, shared by write and read paths
    always_comb
    begin
        addrHit = isMapped(regAddr);
        addrSlot = slotOf(regAddr);
    end

    // one byte register per slot; writes allowed at any time
    for (genvar s = 0; s < SLOTS; s++)
    begin : g_slot
        // write enable for this slot only
        logic slotWr;
        assign slotWr = regWrite && addrHit && (addrSlot == 4'(s));
        tos_prio_byte_reg #(
            .W(`TOS_PRIO_BYTE_W)
        ) u_byte (
            .core_clk(core_clk),
            .reset(reset),
            .wrEn(slotWr),
            .wrData(regWrData),
            .value(slotValue[s])
        );
        // field k of slot s is code point index 4s+k, bits 2k+1..2k
        assign lowBits[s*`TOS_PRIO_BYTE_W +: `TOS_PRIO_BYTE_W] = slotValue[s];
    end

    // full table: this bank low, neighbour bank above it
    assign tableBits = {upperFields, lowBits};

    // read data stand for exactly the cycle after the strobe
    // unmapped addresses and idle cycles read zero
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdData_q <= `TOS_PRIO_RD_IDLE;
        end
        else if (regRead && addrHit)
        begin
            rdData_q <= slotValue[addrSlot];
        end
        else
        begin
            rdData_q <= `TOS_PRIO_RD_IDLE;
        end
    end

    assign regRdData = rdData_q;

    // the two low bits of the type-of-service byte are ignored
    assign codeIdx = tosByte[`TOS_PRIO_IDX_MSB:`TOS_PRIO_IDX_LSB];

    // frames without an IP header never consult the table
    assign useTos = tosPrioEnable && (frameIsIpv4 || frameIsIpv6);

    // combinational field select over all sixty-four entries
    tos_prio_select #(
        .ENTRIES(ENTRIES),
        .FW(FW)
    ) u_select (
        .tableBits(tableBits),
        .codeIdx(codeIdx),
        .prio(prioSel)
    );

    // answer strobe, one cycle after each request
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            prioValid_q <= 1'b0;
        end
        else
        begin
            prioValid_q <= tosValid;
        end
    end

    // priority and its source; a write in the same cycle as a lookup
    // is seen by the next lookup, so the answer uses the old value
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            prio_q <= `TOS_PRIO_NONE;
            fromTos_q <= 1'b0;
        end
        else if (tosValid && useTos)
        begin
            prio_q <= prioSel;
            fromTos_q <= 1'b1;
        end
        else
        begin
            // non-IP, source disabled or idle: the queueing logic picks another source
            prio_q <= `TOS_PRIO_NONE;
            fromTos_q <= 1'b0;
        end
    end

    assign prioValid = prioValid_q;
    assign prioOut = prio_q;
    assign prioFromTos = fromTos_q;

    // lookup answer equals the field picked by bits seven..two
    a_index_upper_bits:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos)
        |=> (prioOut == $past(tableBits[FW*tosByte[7:2] +: FW])))
    else $error("priority not taken from code point field");

    // code point 0x10 uses bits 1..0 of byte 0x60
    a_slot60_low:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h04)
        |=> (prioOut == $past(slotValue[1][1:0])))
    else $error("code 0x10 not mapped to byte 0x60 bits 1..0");

    // code point 0x2C uses bits 7..6 of byte 0x62
    a_slot62_high:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h0B)
        |=> (prioOut == $past(slotValue[2][7:6])))
    else $error("code 0x2C not mapped to byte 0x62 bits 7..6");

    // code point 0x34 uses bits 3..2 of byte 0x63
    a_slot63_mid:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h0D)
        |=> (prioOut == $past(slotValue[3][3:2])))
    else $error("code 0x34 not mapped to byte 0x63 bits 3..2");

    // code point 0x48 uses bits 5..4 of byte 0x64
    a_slot64_mid:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h12)
        |=> (prioOut == $past(slotValue[4][5:4])))
    else $error("code 0x48 not mapped to byte 0x64 bits 5..4");

    // write to 0x65 then lookup of 0x5C returns the written bits 7..6
    a_slot65_write:
    assert property (@(posedge core_clk) disable iff (reset)
        (regWrite && regAddr == `TOS_PRIO_OFS_50_5C)
        ##1 (tosValid && useTos && tosByte[7:2] == 6'h17 && !regWrite)
        |=> (prioOut == $past(regWrData[7:6], 2)))
    else $error("byte 0x65 write not seen by code 0x5C");

    // code point 0x60 uses bits 1..0 of byte 0x66
    a_slot66_low:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h18)
        |=> (prioOut == $past(slotValue[6][1:0])))
    else $error("code 0x60 not mapped to byte 0x66 bits 1..0");

    // code point 0x78 uses bits 5..4 of byte 0x67
    a_slot67_mid:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h1E)
        |=> (prioOut == $past(slotValue[7][5:4])))
    else $error("code 0x78 not mapped to byte 0x67 bits 5..4");

    // code point 0x8C uses bits 7..6 of byte 0x68
    a_slot68_high:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h23)
        |=> (prioOut == $past(slotValue[8][7:6])))
    else $error("code 0x8C not mapped to byte 0x68 bits 7..6");

    // code points past this bank come from the neighbour fields
    a_upper_entries:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] >= 6'h24)
        |=> (prioOut == $past(upperFields[FW*(tosByte[7:2] - 6'h24) +: FW])))
    else $error("upper code point not taken from neighbour fields");

    // code point 0x0C uses bits 7..6 of the lowest byte
    a_slot_lowest:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && useTos && tosByte[7:2] == 6'h03)
        |=> (prioOut == $past(slotValue[0][7:6])))
    else $error("code 0x0C not mapped to lowest byte bits 7..6");

    // write then read back of the same mapped byte returns the data
    a_write_readback:
    assert property (@(posedge core_clk) disable iff (reset)
        (regWrite && addrHit) ##1 (regRead && $stable(regAddr))
        |=> (regRdData == $past(regWrData, 2)))
    else $error("mapped byte did not read back written value");

    // every byte is zero on the first edge after reset
    a_reset_clear:
    assert property (@(posedge core_clk) disable iff (reset)
        $past(reset) |-> (lowBits == '0 && regRdData == `TOS_PRIO_RD_IDLE))
    else $error("table not cleared by reset");

    // unmapped reads and idle cycles answer zero
    a_unmapped_zero:
    assert property (@(posedge core_clk) disable iff (reset)
        !(regRead && addrHit) |=> (regRdData == `TOS_PRIO_RD_IDLE))
    else $error("read data not zero outside a mapped read");

    // non-IP frames never claim this priority, whatever the source enable
    a_non_ip_ignored:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && !(frameIsIpv4 || frameIsIpv6))
        |=> (!prioFromTos && prioOut == `TOS_PRIO_NONE && prioValid))
    else $error("non-IP frame used the lookup priority");

    // IP frames with the source enabled are answered from the table
    a_ip_answered:
    assert property (@(posedge core_clk) disable iff (reset)
        (tosValid && tosPrioEnable && (frameIsIpv4 || frameIsIpv6))
        |=> (prioValid && prioFromTos))
    else $error("IP frame not answered from the table");

    // answer strobe follows each request by one cycle only
    a_valid_follows:
    assert property (@(posedge core_clk) disable iff (reset)
        prioValid == $past(tosValid))
    else $error("answer strobe not one cycle after request");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`include "tos_prio_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and bench bookkeeping
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    int mismatches = 0;
    int comparisons = 0;
    integer seed = 56700;
    // register port
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [7:0] regRdData;
    // parser side and neighbour bank fields
    logic [55:0] upperFields = 56'h0;
    logic tosValid = 1'h0;
    logic [7:0] tosByte = 8'h00;
    logic frameIsIpv4 = 1'h0;
    logic frameIsIpv6 = 1'h0;
    logic tosPrioEnable = 1'h0;
    // queueing side
    logic prioValid;
    logic [1:0] prioOut;
    logic prioFromTos;
    // model: one byte per slot, expected outputs for the next edge
    int tbl[9];
    logic [7:0] expRd = 8'h00;
    logic expValid = 1'h0;
    logic [1:0] expPrio = 2'h0;
    logic expFrom = 1'h0;
    // directed pass scratch
    logic [7:0] b;
    logic [7:0] ofsTab[9] = '{`TOS_PRIO_OFS_00_0C, `TOS_PRIO_OFS_10_1C, `TOS_PRIO_OFS_20_2C,
        `TOS_PRIO_OFS_30_3C, `TOS_PRIO_OFS_40_4C, `TOS_PRIO_OFS_50_5C, `TOS_PRIO_OFS_60_6C,
        `TOS_PRIO_OFS_70_7C, `TOS_PRIO_OFS_80_8C};

    tos_priority_lookup_table dut_u (
        .core_clk(core_clk),
        .reset(reset),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .upperFields(upperFields),
        .tosValid(tosValid),
        .tosByte(tosByte),
        .frameIsIpv4(frameIsIpv4),
        .frameIsIpv6(frameIsIpv6),
        .tosPrioEnable(tosPrioEnable),
        .prioValid(prioValid),
        .prioOut(prioOut),
        .prioFromTos(prioFromTos)
    );

    // free running core clock, 50 ns period
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // single comparison point, counts every compare
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // address to slot; -1 for anything not stored here (0x61 included)
    function automatic int slotOf(input logic [7:0] a);
        if (a == `TOS_PRIO_OFS_00_0C)
            return 0;
        if (a == `TOS_PRIO_OFS_10_1C)
            return 1;
        if (a >= `TOS_PRIO_OFS_20_2C && a <= `TOS_PRIO_OFS_80_8C)
            return int'(a) - 'h60;
        return -1;
    endfunction

    // field for a code index: low 36 from the bank, the rest from the neighbour
    function automatic int lookFor(input int idx);
        if (idx < 36)
            return (tbl[idx / 4] >> (2 * (idx % 4))) & 3;
        return int'((upperFields >> (2 * (idx - 36))) & 56'h3);
    endfunction

    // one bus cycle on every input, driven just after the rising edge
    task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        input logic tv, input logic [7:0] tb, input logic [2:0] fl);
        @(posedge core_clk);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWrData <= d;
        tosValid <= tv;
        tosByte <= tb;
        frameIsIpv4 <= fl[0];
        frameIsIpv6 <= fl[1];
        tosPrioEnable <= fl[2];
    endtask

    // no strobes, but the qualifiers still wander so stale values cannot hide
    task automatic idle();
        drive(1'h0, 1'h0, 8'($random(seed)), 8'($random(seed)), 1'h0, 8'($random(seed)),
            3'($random(seed)));
    endtask

    // reads every address around the bank, unmapped places included
    task automatic sweep();
        for (int a = 'h5C; a <= 'h6B; a++)
            drive(1'h0, 1'h1, 8'(a), 8'($random(seed)), 1'h0, 8'h00, 3'h0);
        idle();
    endtask

    // model compare at each edge, then predict the next edge from the inputs sampled now
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            foreach (tbl[i])
                tbl[i] = 0;
            expRd = 8'h00;
            expValid = 1'h0;
            expPrio = 2'h0;
            expFrom = 1'h0;
        end
        else
        begin
            check(regRdData, expRd, "read data");
            check({7'h00, prioValid}, {7'h00, expValid}, "valid");
            check({6'h00, prioOut}, {6'h00, expPrio}, "priority");
            check({7'h00, prioFromTos}, {7'h00, expFrom}, "source");
            expRd = (regRead && slotOf(regAddr) >= 0) ? 8'(tbl[slotOf(regAddr)]) : 8'h00;
            expValid = tosValid;
            expFrom = tosValid && (frameIsIpv4 || frameIsIpv6) && tosPrioEnable;
            // a lookup beside a write sees the old byte, so predict before updating
            expPrio = expFrom ? 2'(lookFor(int'(tosByte[7:2]))) : 2'h0;
            if (regWrite && slotOf(regAddr) >= 0)
                tbl[slotOf(regAddr)] = int'(regWrData);
        end
    end

    // watchdog: the whole run needs well under 5000 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        // every byte starts at zero, unmapped reads give zero
        sweep();
        // each byte: four fields, low bits of the type-of-service byte ignored
        for (int i = 0; i < 9; i++)
        begin
            b = 8'($random(seed));
            drive(1'h1, 1'h0, ofsTab[i], b, 1'h0, 8'h00, 3'h0);
            // highest field first: the lookup right after the write hits the new byte at once
            for (int k = 3; k >= 0; k--)
            begin
                drive(1'h0, 1'h0, 8'h00, 8'h00, 1'h1, 8'(16 * i + 4 * k) | 8'($random(seed) & 3),
                    k[0] ? 3'h6 : 3'h5);
                idle();
                #1 check({6'h00, prioOut}, {6'h00, b[2 * k +: 2]}, "field");
            end
        end
        // random back to back traffic: writes, reads, lookups, all source modes
        repeat (3000)
        begin
            case ({$random(seed)} % 3)
                0: drive(1'h0, 1'h0, 8'h5C + 8'({$random(seed)} % 16), 8'($random(seed)),
                    1'($random(seed)), 8'($random(seed)), 3'($random(seed)));
                1: drive(1'h1, 1'h0, 8'h5C + 8'({$random(seed)} % 16), 8'($random(seed)),
                    1'($random(seed)), 8'($random(seed)), 3'($random(seed)));
                default: drive(1'h0, 1'h1, 8'h5C + 8'({$random(seed)} % 16), 8'($random(seed)),
                    1'($random(seed)), 8'($random(seed)), 3'($random(seed)));
            endcase
            if ({$random(seed)} % 8 == 0)
                upperFields <= 56'({$random(seed), $random(seed)});
        end
        // second reset in mid-run, asserted away from the edge
        idle();
        @(negedge core_clk);
        reset = 1'h1;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        // bytes must be zero again
        sweep();
        repeat (3) idle();
        end_sim();
    end
endmodule
`default_nettype wire
